// ===== rtl/cpu_regs_cfg.svh
/*
 Register offsets, status word field positions, reset values for the core register set.
 Assumes inclusion by the register file only.
*/
// Functional notes
// RULE_01: thirteen registers, seven banked in two copies
// RULE_02: 16-bit data words, words 0/1 byte halves
// RULE_03: words 2:0 and 3:1 form 32-bit pairs
// RULE_04: address words join, word 1 upper
// RULE_05: 16-bit frame base for frame addressing
// RULE_06: 20-bit instruction pointer
// RULE_07: 20-bit vector table base
// RULE_08: user and interrupt stack, one active
// RULE_09: 16-bit static base register
// RULE_10: status word has eleven flag bits
// RULE_11: bit 0 holds ALU carry
// RULE_12: bit 1 single-step, cleared on acknowledge
// RULE_13: bit 2 set on zero result
// RULE_14: bit 3 set on negative result
// RULE_15: bit 4 selects register bank
// RULE_16: bit 5 set on overflow
// RULE_17: bit 6 enables interrupts, cleared on acknowledge
// RULE_18: stack bit 0 interrupt, 1 user
// RULE_19: stack bit cleared on hardware/soft 0-31
// RULE_20: bits 8-11 reserved, 12-14 priority
// RULE_21: accept only priority above current level
// RULE_22: bit 15 reserved
// RULE_23: reserved bits ignore writes, read zero
`ifndef CPU_REGS_CFG_SVH
`define CPU_REGS_CFG_SVH

// word offsets on the bus, byte address = 4 * index
`define OFS_DATA_WORD_0 8'h00
`define OFS_DATA_WORD_1 8'h04
`define OFS_DATA_WORD_2 8'h08
`define OFS_DATA_WORD_3 8'h0C
`define OFS_ADDR_WORD_0 8'h10
`define OFS_ADDR_WORD_1 8'h14
`define OFS_FRAME_BASE 8'h18
`define OFS_INSTR_POINTER 8'h1C
`define OFS_VECTOR_TABLE_BASE 8'h20
`define OFS_USER_STACK_PTR 8'h24
`define OFS_IRQ_STACK_PTR 8'h28
`define OFS_STATIC_BASE 8'h2C
`define OFS_STATUS_WORD 8'h30

// status word field positions
`define SW_CARRY 0
`define SW_STEP 1
`define SW_ZERO 2
`define SW_SIGN 3
`define SW_BANK 4
`define SW_OVFL 5
`define SW_IEN 6
`define SW_STACK 7
`define SW_PRIO_LO 12
`define SW_PRIO_HI 14
`define SW_IMPL_MASK 16'h70FF
`define SW_SOFT_CLR_MAX 6'h1F

// reset values
`define RST_WORD16 16'h0000
`define RST_WORD20 20'h00000
`define RST_STATUS 16'h0000

`endif

// ===== rtl/cpu_regs_pkg.sv
/*
 Types for the core register set.
 Assumes cpu_regs_cfg.svh is on the include path.
*/
package cpu_regs_pkg;
    // datapath write port toward one architectural register
    typedef enum logic [3:0] {
        SEL_DW0, SEL_DW1, SEL_DW2, SEL_DW3, SEL_AW0, SEL_AW1, SEL_FB,
        SEL_IP, SEL_VTB, SEL_USP, SEL_ISP, SEL_SB, SEL_STATUS, SEL_SP
    } reg_sel_e;

    typedef struct packed {
        logic en;
        reg_sel_e sel;
        logic [1:0] bmask;  // bit0 low byte, bit1 high byte
        logic [19:0] data;
    } core_wr_s;

    // flag update from the ALU
    typedef struct packed {
        logic upd_c;
        logic upd_z;
        logic upd_s;
        logic upd_o;
        logic carry;
        logic [15:0] result;
        logic ovfl;
    } alu_flags_s;

    typedef struct packed {
        logic req;
        logic [2:0] prio;
        logic maskable;
    } irq_req_s;
endpackage

// ===== rtl/cpu_register_set_with_flags.sv
/*
 Core register set: banked data/address/frame registers, pointers, stacks and status word.
 Assumes the datapath gives at most one register write per cycle, Wishbone classic slave.
*/
`timescale 1ns/100ps
`include "cpu_regs_cfg.svh"
module cpu_register_set_with_flags (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    input wire logic i_wb_we,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire cpu_regs_pkg::core_wr_s i_core_wr,
    input wire cpu_regs_pkg::alu_flags_s i_alu,
    input wire logic i_instr_done,
    input wire cpu_regs_pkg::irq_req_s i_irq,
    input wire logic i_irq_ack,
    input wire logic i_step_ack,
    input wire logic i_soft_int,
    input wire logic [5:0] i_soft_int_num,
    output logic [15:0] o_data_word_0,
    output logic [15:0] o_data_word_1,
    output logic [15:0] o_data_word_2,
    output logic [15:0] o_data_word_3,
    output logic [7:0] o_data_word_0_high,
    output logic [7:0] o_data_word_0_low,
    output logic [7:0] o_data_word_1_high,
    output logic [7:0] o_data_word_1_low,
    output logic [31:0] o_data_pair_low,
    output logic [31:0] o_data_pair_high,
    output logic [31:0] o_addr_pair,
    output logic [15:0] o_frame_base,
    output logic [19:0] o_instr_pointer,
    output logic [19:0] o_vector_table_base,
    output logic [15:0] o_stack_ptr,
    output logic [15:0] o_static_base,
    output logic [15:0] o_status_word,
    output logic o_step_irq,
    output logic o_irq_accept
);
    // banked registers: index 0..6 = dw0..dw3, aw0, aw1, frame base
    logic [15:0] bank_reg [2][7];
    logic [19:0] ip_reg;
    logic [19:0] vtb_reg;
    logic [15:0] usp_reg;
    logic [15:0] isp_reg;
    logic [15:0] sb_reg;
    logic [15:0] sw_reg;
    logic [15:0] sw_next;
    logic ack_reg;

    // bus decode
    wire logic bus_req = i_wb_cyc && i_wb_stb && !ack_reg;
    // a write lands at the edge where the master sees ack, while it still holds the request
    wire logic bus_wr = i_wb_cyc && i_wb_stb && i_wb_we && ack_reg;
    wire logic [3:0] bus_idx = i_wb_adr[5:2];
    wire logic bus_hit = (i_wb_adr[1:0] == 2'h0) && (i_wb_adr[7:6] == 2'h0)
        && (bus_idx <= 4'hC);
    wire logic [1:0] bus_bmask = i_wb_sel[1:0];

    wire logic bank = sw_reg[`SW_BANK]; // RULE_15
    wire logic stack_sel = sw_reg[`SW_STACK];

    // a bus write drops the datapath write of the same cycle, whichever register either one targets
    wire logic any_wr = bus_wr ? bus_hit : i_core_wr.en;
    wire cpu_regs_pkg::reg_sel_e wr_sel = bus_wr ? cpu_regs_pkg::reg_sel_e'(bus_idx)
        : i_core_wr.sel;
    wire logic [1:0] wr_bm = bus_wr ? bus_bmask : i_core_wr.bmask;
    wire logic [19:0] wr_data = bus_wr ? i_wb_dat[19:0] : i_core_wr.data;
    // the active stack write resolves through the stack choice bit
    wire cpu_regs_pkg::reg_sel_e wr_tgt = (wr_sel == cpu_regs_pkg::SEL_SP)
        ? (stack_sel ? cpu_regs_pkg::SEL_USP : cpu_regs_pkg::SEL_ISP) : wr_sel; // RULE_18

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] bm);
        merge16 = {bm[1] ? nw[15:8] : old[15:8], bm[0] ? nw[7:0] : old[7:0]}; // RULE_02
    endfunction

    // banked words, one process per entry and copy so each element has one driver
    for (genvar g = 0; g < 7; g++) begin : g_bank
        for (genvar b = 0; b < 2; b++) begin : g_copy
            wire logic hit = any_wr && (wr_tgt == cpu_regs_pkg::reg_sel_e'(g))
                && (bank == 1'(b)); // RULE_01
            always_ff @(posedge i_clk_sys) begin
                if (i_srst) begin
                    bank_reg[b][g] <= `RST_WORD16;
                end else if (hit) begin
                    bank_reg[b][g] <= merge16(bank_reg[b][g], wr_data[15:0], wr_bm);
                end
            end
        end
    end

    // instruction pointer is read-only on the bus; the datapath steers it
    wire logic ip_we = i_core_wr.en && !bus_wr && (i_core_wr.sel == cpu_regs_pkg::SEL_IP);
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ip_reg <= `RST_WORD20;
        end else if (ip_we) begin
            ip_reg <= i_core_wr.data; // RULE_06
        end
    end

    // pointers and static base; 20-bit table base uses all of write data
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            vtb_reg <= `RST_WORD20;
            usp_reg <= `RST_WORD16;
            isp_reg <= `RST_WORD16;
            sb_reg <= `RST_WORD16;
        end else if (any_wr) begin
            if (wr_tgt == cpu_regs_pkg::SEL_VTB) begin
                vtb_reg <= wr_data; // RULE_07
            end
            if (wr_tgt == cpu_regs_pkg::SEL_USP) begin
                usp_reg <= merge16(usp_reg, wr_data[15:0], wr_bm); // RULE_08
            end
            if (wr_tgt == cpu_regs_pkg::SEL_ISP) begin
                isp_reg <= merge16(isp_reg, wr_data[15:0], wr_bm); // RULE_08
            end
            if (wr_tgt == cpu_regs_pkg::SEL_SB) begin
                sb_reg <= merge16(sb_reg, wr_data[15:0], wr_bm); // RULE_09
            end
        end
    end

    // interrupt acceptance: priority must beat the current level and, if maskable, enable
    wire logic [2:0] cur_prio = sw_reg[`SW_PRIO_HI:`SW_PRIO_LO];
    assign o_irq_accept = i_irq.req && (i_irq.prio > cur_prio)
        && (!i_irq.maskable || sw_reg[`SW_IEN]); // RULE_21 RULE_17
    assign o_step_irq = sw_reg[`SW_STEP] && i_instr_done; // RULE_12

    // status word: explicit writes first, then hardware events override them
    wire logic sw_wr = any_wr && (wr_sel == cpu_regs_pkg::SEL_STATUS);
    wire logic soft_low = i_soft_int && (i_soft_int_num <= `SW_SOFT_CLR_MAX);
    always_comb begin
        sw_next = sw_reg;
        if (sw_wr) begin
            sw_next = merge16(sw_reg, wr_data[15:0], wr_bm) & `SW_IMPL_MASK; // RULE_23 RULE_20
        end
        if (i_alu.upd_c) begin
            sw_next[`SW_CARRY] = i_alu.carry; // RULE_11
        end
        if (i_alu.upd_z) begin
            sw_next[`SW_ZERO] = (i_alu.result == 16'h0000); // RULE_13
        end
        if (i_alu.upd_s) begin
            sw_next[`SW_SIGN] = i_alu.result[15]; // RULE_14
        end
        if (i_alu.upd_o) begin
            sw_next[`SW_OVFL] = i_alu.ovfl; // RULE_16
        end
        if (i_step_ack) begin
            sw_next[`SW_STEP] = 1'b0; // RULE_12
        end
        if (i_irq_ack) begin
            sw_next[`SW_IEN] = 1'b0; // RULE_17
            sw_next[`SW_STACK] = 1'b0; // RULE_19
        end
        if (soft_low) begin
            sw_next[`SW_STACK] = 1'b0; // RULE_19
        end
        sw_next = sw_next & `SW_IMPL_MASK; // RULE_10 RULE_22
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sw_reg <= `RST_STATUS;
        end else begin
            sw_reg <= sw_next;
        end
    end

    // bus answer: registered ack one cycle after the request, ack dropped the cycle after
    logic [19:0] rd_mux;
    always_comb begin
        unique case (bus_idx)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: rd_mux = {4'h0, bank_reg[bank][bus_idx[2:0]]};
            4'h7: rd_mux = ip_reg;
            4'h8: rd_mux = vtb_reg;
            4'h9: rd_mux = {4'h0, usp_reg};
            4'hA: rd_mux = {4'h0, isp_reg};
            4'hB: rd_mux = {4'h0, sb_reg};
            4'hC: rd_mux = {4'h0, sw_reg};
            default: rd_mux = 20'h00000;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ack_reg <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            ack_reg <= bus_req;
            o_wb_dat <= (bus_req && bus_hit) ? {12'h000, rd_mux} : 32'h00000000;
        end
    end
    assign o_wb_ack = ack_reg;

    // datapath views of the active bank and of the unbanked registers
    assign o_data_word_0 = bank_reg[bank][0];
    assign o_data_word_1 = bank_reg[bank][1];
    assign o_data_word_2 = bank_reg[bank][2];
    assign o_data_word_3 = bank_reg[bank][3];
    assign o_data_word_0_high = bank_reg[bank][0][15:8]; // RULE_02
    assign o_data_word_0_low = bank_reg[bank][0][7:0];
    assign o_data_word_1_high = bank_reg[bank][1][15:8];
    assign o_data_word_1_low = bank_reg[bank][1][7:0];
    assign o_data_pair_low = {bank_reg[bank][2], bank_reg[bank][0]}; // RULE_03
    assign o_data_pair_high = {bank_reg[bank][3], bank_reg[bank][1]}; // RULE_03
    assign o_addr_pair = {bank_reg[bank][5], bank_reg[bank][4]}; // RULE_04
    assign o_frame_base = bank_reg[bank][6]; // RULE_05
    assign o_instr_pointer = ip_reg;
    assign o_vector_table_base = vtb_reg;
    assign o_stack_ptr = stack_sel ? usp_reg : isp_reg; // RULE_18
    assign o_static_base = sb_reg;
    assign o_status_word = sw_reg;

    AST_RESERVED_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (sw_reg & ~`SW_IMPL_MASK) == 16'h0000) else $error("reserved bits set"); // RULE_23
    AST_ACK_CLEARS_IEN: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        i_irq_ack |=> !sw_reg[`SW_IEN] && !sw_reg[`SW_STACK]) else $error("ack kept I/U"); // RULE_17
    AST_SOFT_CLR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        soft_low |=> !sw_reg[`SW_STACK]) else $error("soft int kept U"); // RULE_19
    AST_STEP_CLR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        i_step_ack |=> !sw_reg[`SW_STEP]) else $error("step not cleared"); // RULE_12
    AST_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        i_alu.upd_z && !i_step_ack |=> sw_reg[`SW_ZERO] == ($past(i_alu.result) == 16'h0000))
        else $error("zero flag wrong"); // RULE_13
    AST_SIGN: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        i_alu.upd_s |=> sw_reg[`SW_SIGN] == $past(i_alu.result[15])) else $error("sign wrong"); // RULE_14
    AST_CARRY: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        i_alu.upd_c |=> sw_reg[`SW_CARRY] == $past(i_alu.carry)) else $error("carry wrong"); // RULE_11
    AST_ACCEPT: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        o_irq_accept |-> i_irq.prio > sw_reg[`SW_PRIO_HI:`SW_PRIO_LO]) else $error("low prio taken"); // RULE_21
    AST_STACK: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        o_stack_ptr == (sw_reg[`SW_STACK] ? usp_reg : isp_reg)) else $error("wrong stack"); // RULE_18
    AST_ACK_DROP: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        o_wb_ack |=> !o_wb_ack) else $error("ack held");

    COV_IRQ: cover property (@(posedge i_clk_sys) o_irq_accept ##1 i_irq_ack);
    COV_BANK: cover property (@(posedge i_clk_sys) !bank ##[1:20] bank);
    COV_WR: cover property (@(posedge i_clk_sys) bus_req && i_wb_we ##1 bus_wr && bus_hit);
    COV_STEP: cover property (@(posedge i_clk_sys) o_step_irq ##1 i_step_ack);
endmodule

// ===== verif/core_ack_model.sv
/*
 Behavioural model of the core datapath acknowledge logic facing the register set.
 Assumes the register set's accept and single-step requests are combinational levels.
*/
`timescale 1ns/100ps
module core_ack_model (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_irq_accept,
    input wire logic i_step_irq,
    output logic o_irq_ack,
    output logic o_step_ack
);
    // acknowledge one cycle after a request is seen; never twice in a row
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_irq_ack <= 1'b0;
            o_step_ack <= 1'b0;
        end else begin
            o_irq_ack <= i_irq_accept & ~o_irq_ack;
            o_step_ack <= i_step_irq & ~o_step_ack;
        end
    end
endmodule

// ===== verif/tb_top.sv
/*
 Self-checking bench for the core register set: bus access, banks, flags, interrupts.
 Assumes a classic Wishbone slave answering with a one-cycle ack and an acking core model.
*/
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'h0;
    logic wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0;
    cpu_regs_pkg::core_wr_s core_wr = '0;
    cpu_regs_pkg::alu_flags_s alu = '0;
    cpu_regs_pkg::irq_req_s irq = '0;
    logic instr_done = 1'b0, soft_int = 1'b0;
    logic [5:0] soft_num = 6'h00;
    logic [31:0] rd_dat, pair_lo, pair_hi, addr_pair, rdq, rnd;
    logic wb_ack, step_irq, irq_accept, irq_ack, step_ack;
    logic [15:0] dw0, dw1, dw2, dw3, fb, sb_o, sw_o, stack_ptr;
    logic [7:0] dw0_hi, dw0_lo, dw1_hi, dw1_lo;
    logic [19:0] ip, vtb;
    int err_count = 0;
    int checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    cpu_register_set_with_flags u_dut (
        .i_clk_sys(clk_sys), .i_srst(srst), .i_wb_adr(wb_adr), .i_wb_dat(wb_dat),
        .i_wb_sel(wb_sel), .i_wb_we(wb_we), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .o_wb_dat(rd_dat), .o_wb_ack(wb_ack), .i_core_wr(core_wr), .i_alu(alu),
        .i_instr_done(instr_done), .i_irq(irq), .i_irq_ack(irq_ack),
        .i_step_ack(step_ack), .i_soft_int(soft_int), .i_soft_int_num(soft_num),
        .o_data_word_0(dw0), .o_data_word_1(dw1), .o_data_word_2(dw2), .o_data_word_3(dw3),
        .o_data_word_0_high(dw0_hi), .o_data_word_0_low(dw0_lo),
        .o_data_word_1_high(dw1_hi), .o_data_word_1_low(dw1_lo), .o_data_pair_low(pair_lo),
        .o_data_pair_high(pair_hi), .o_addr_pair(addr_pair), .o_frame_base(fb),
        .o_instr_pointer(ip), .o_vector_table_base(vtb), .o_stack_ptr(stack_ptr),
        .o_static_base(sb_o), .o_status_word(sw_o), .o_step_irq(step_irq),
        .o_irq_accept(irq_accept)
    );

    core_ack_model u_core (
        .i_clk_sys(clk_sys), .i_srst(srst), .i_irq_accept(irq_accept),
        .i_step_irq(step_irq), .o_irq_ack(irq_ack), .o_step_ack(step_ack)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // read-back value: pointer is read-only, reserved status bits read zero
    function automatic logic [31:0] exp_rd(input logic [7:0] a, input logic [31:0] d);
        if (a == 8'h1C) return 32'h0;
        if (a == 8'h20) return {12'h000, d[19:0]};
        if (a == 8'h30) return d & 32'h0000_70FF;
        return {16'h0000, d[15:0]};
    endfunction

    function automatic logic [31:0] exp_flags(input logic [15:0] r, input logic c, o);
        return {26'h0, o, 1'b0, r[15], (r == 16'h0000), 1'b0, c};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; waits for ack, takes data at that edge, then idles a cycle
    task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        wb_adr <= a;
        wb_we <= we;
        wb_dat <= d;
        wb_sel <= s;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        rdq = rd_dat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic pulse_core(input cpu_regs_pkg::reg_sel_e s, input logic [19:0] d);
        core_wr <= '{1'b1, s, 2'b11, d};
        @(posedge clk_sys);
        core_wr <= '0;
        @(posedge clk_sys);
    endtask

    task automatic final_report;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        final_report();
    end

    initial begin
        int i;
        logic [31:0] v [13];
        logic [15:0] r;
        rnd = 32'hC6D64090;
        repeat (21) @(posedge clk_sys);
        for (i = 0; i < 13; i++) begin
            bus(8'(i * 4), 1'b0, 32'h0, 4'hF);
            chk(rdq, 32'h0);
        end
        for (i = 0; i < 13; i++) begin
            rnd = lfsr(rnd);
            v[i] = rnd;
            bus(8'(i * 4), 1'b1, rnd, 4'hF);
            bus(8'(i * 4), 1'b0, 32'h0, 4'hF);
            chk(rdq, exp_rd(8'(i * 4), rnd));
        end
        bus(8'h30, 1'b1, 32'h0, 4'hF);
        chk(pair_hi, {v[3][15:0], v[1][15:0]});
        chk({dw1_hi, dw1_lo, dw2}, {v[1][15:0], v[2][15:0]});
        chk({dw1, dw3}, {v[1][15:0], v[3][15:0]});
        chk({16'h0, fb}, {16'h0, v[6][15:0]});
        chk({12'h0, vtb}, {12'h0, v[8][19:0]});
        chk({16'h0, sb_o}, {16'h0, v[11][15:0]});
        bus(8'h34, 1'b1, 32'hFFFF_FFFF, 4'hF);
        bus(8'h34, 1'b0, 32'h0, 4'hF);
        chk(rdq, 32'h0);
        // bank swap keeps two copies of data word 0
        bus(8'h00, 1'b1, 32'h1111, 4'hF);
        bus(8'h30, 1'b1, 32'h0010, 4'hF);
        bus(8'h00, 1'b1, 32'h2222, 4'hF);
        chk({16'h0, dw0}, 32'h2222);
        bus(8'h30, 1'b1, 32'h0, 4'hF);
        bus(8'h00, 1'b0, 32'h0, 4'hF);
        chk(rdq, 32'h1111);
        bus(8'h00, 1'b1, 32'hABCD, 4'h2);
        chk({16'h0, dw0_hi, dw0_lo}, 32'hAB11);
        bus(8'h08, 1'b1, 32'h2222, 4'hF);
        chk(pair_lo, 32'h2222_AB11);
        bus(8'h10, 1'b1, 32'h5A5A, 4'hF);
        bus(8'h14, 1'b1, 32'hC3C3, 4'hF);
        chk(addr_pair, 32'hC3C3_5A5A);
        // stack choice and datapath writes
        bus(8'h24, 1'b1, 32'h1234, 4'hF);
        bus(8'h28, 1'b1, 32'h5678, 4'hF);
        chk({16'h0, stack_ptr}, 32'h5678);
        bus(8'h30, 1'b1, 32'h0080, 4'hF);
        chk({16'h0, stack_ptr}, 32'h1234);
        pulse_core(cpu_regs_pkg::SEL_SP, 20'h0ABCD);
        bus(8'h24, 1'b0, 32'h0, 4'hF);
        chk(rdq, 32'hABCD);
        pulse_core(cpu_regs_pkg::SEL_IP, 20'hFEDCB);
        chk({12'h0, ip}, 32'hFEDCB);
        // arithmetic flags from a zero, a negative and two pseudo-random results
        for (i = 0; i < 4; i++) begin
            bus(8'h30, 1'b1, 32'h0, 4'hF);
            rnd = lfsr(rnd);
            r = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : rnd[15:0];
            alu <= '{1'b1, 1'b1, 1'b1, 1'b1, i[0], r, i[1]};
            @(posedge clk_sys);
            alu <= '0;
            @(posedge clk_sys);
            bus(8'h30, 1'b0, 32'h0, 4'hF);
            chk(rdq, exp_flags(r, i[0], i[1]));
            chk({16'h0, sw_o}, exp_flags(r, i[0], i[1]));
        end
        // single step request and its acknowledge
        bus(8'h30, 1'b1, 32'h0002, 4'hF);
        instr_done <= 1'b1;
        @(negedge clk_sys);
        chk({31'h0, step_irq}, 32'h1);
        @(posedge clk_sys);
        instr_done <= 1'b0;
        repeat (3) @(posedge clk_sys);
        bus(8'h30, 1'b0, 32'h0, 4'hF);
        chk(rdq & 32'h2, 32'h0);
        // priority compare, enable gate, acknowledge side effects
        bus(8'h30, 1'b1, 32'h30C0, 4'hF);
        irq <= '{1'b1, 3'd3, 1'b1};
        @(negedge clk_sys);
        chk({31'h0, irq_accept}, 32'h0);
        @(posedge clk_sys);
        irq <= '{1'b1, 3'd4, 1'b1};
        @(negedge clk_sys);
        chk({31'h0, irq_accept}, 32'h1);
        @(posedge clk_sys);
        irq <= '0;
        repeat (3) @(posedge clk_sys);
        bus(8'h30, 1'b0, 32'h0, 4'hF);
        chk(rdq & 32'hC0, 32'h0);
        bus(8'h30, 1'b1, 32'h3080, 4'hF);
        irq <= '{1'b1, 3'd7, 1'b1};
        @(negedge clk_sys);
        chk({31'h0, irq_accept}, 32'h0);
        @(posedge clk_sys);
        irq <= '{1'b1, 3'd7, 1'b0};
        @(negedge clk_sys);
        chk({31'h0, irq_accept}, 32'h1);
        @(posedge clk_sys);
        irq <= '0;
        repeat (3) @(posedge clk_sys);
        bus(8'h30, 1'b0, 32'h0, 4'hF);
        chk(rdq & 32'h80, 32'h0);
        // software interrupt numbers at and past the boundary
        for (i = 0; i < 3; i++) begin
            bus(8'h30, 1'b1, 32'h0080, 4'hF);
            soft_num <= (i == 0) ? 6'h00 : (i == 1) ? 6'h1F : 6'h20;
            soft_int <= 1'b1;
            @(posedge clk_sys);
            soft_int <= 1'b0;
            @(posedge clk_sys);
            bus(8'h30, 1'b0, 32'h0, 4'hF);
            chk(rdq & 32'h80, (i == 2) ? 32'h80 : 32'h0);
        end
        final_report();
    end
endmodule
